// file: hw/dio_alarm_params.svh
// Purpose: constants for the 32-channel digital i/o block with alarm capture
// Assumes: byte-wide access at offsets 0..3 from the module base
// Notes: offsets are byte indexes within the module's four-byte window
`ifndef DIO_ALARM_PARAMS_SVH
`define DIO_ALARM_PARAMS_SVH
`define OFS_BYTE0 2'h0
`define OFS_BYTE1 2'h1
`define OFS_BYTE2 2'h2
`define OFS_ALARM 2'h3
`define ALARM_FLAG_LSB 0
`define ALARM_SNAP_LSB 4
`define ALARM_IN_LSB 4
`define ALARM_EN_LSB 0
`define ALARM_RESET 8'h00
`define OUT_RESET 32'h0000_0000
`endif

// file: hw/dio_alarm_pkg.sv
// Purpose: types for the digital i/o alarm block
// Assumes: nothing beyond the constants header
// Notes: bus request and answer carried as structs
package dio_alarm_pkg;
	// cpu side byte request
	typedef struct packed
	{
		logic rd;
		logic wr;
		logic [1:0] ofs;
		logic [7:0] wdata;
	} bus_req_type;
	// read answer
	typedef struct packed
	{
		logic rvalid;
		logic [7:0] rdata;
	} bus_rsp_type;
endpackage

// file: hw/input_sync.sv
// Purpose: two-stage synchroniser for the field input bits and the supply and mode pins
// Assumes: one core clock
// Notes: first stage read only by second stage
`timescale 1ns/100ps
module input_sync
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// raw and synchronised levels
	input wire logic [33:0] raw,
	output logic [33:0] sync
);
	// metastability stage
	logic [33:0] meta_r;
	logic [33:0] meta_nxt;
	logic [33:0] sync_r;
	logic [33:0] sync_nxt;
	// next values are simple shifts
	always_comb
	begin
		meta_nxt = raw;
		sync_nxt = meta_r;
	end
	// register both stages
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			meta_r <= 34'h0_0000_0000;
			sync_r <= 34'h0_0000_0000;
		end
		else
		begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end
	assign sync = sync_r;
endmodule

// file: hw/digital_io_alarm_capture.sv
// Purpose: 32 inputs and 32 outputs in four bytes each, optional alarm capture
// Assumes: cpu issues single-cycle byte reads and writes; pins are asynchronous
// Notes: mode and supply are pins, synchronised before use; restart is used unsynchronised
`timescale 1ns/100ps
`include "dio_alarm_params.svh"
module digital_io_alarm_capture
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// cpu byte bus
	input wire dio_alarm_pkg::bus_req_type bus_req,
	output dio_alarm_pkg::bus_rsp_type bus_rsp,
	// field pins and selectors
	input wire logic [31:0] field_in,
	input wire logic input_load_supply,
	input wire logic alarm_mode_on,
	input wire logic restart_active,
	// field outputs
	output logic [31:0] field_out,
	output logic [31:0] input_led,
	output logic alarm_pending
);
	// synchronised pins
	logic [33:0] sync_all;
	logic [31:0] in_s;
	logic supply_s;
	logic alarm_on_s;
	// restart is cpu-side logic, same clock
	logic [31:0] in_eff;
	// output latches
	logic [31:0] out_r;
	logic [31:0] out_nxt;
	// alarm byte and previous alarm input levels
	logic [7:0] alarm_r;
	logic [7:0] alarm_nxt;
	logic [3:0] prev_r;
	logic [3:0] prev_nxt;
	// read answer registers
	dio_alarm_pkg::bus_rsp_type rsp_r;
	dio_alarm_pkg::bus_rsp_type rsp_nxt;
	// indicator levels, registered so the led pins never glitch
	logic [31:0] led_r;
	logic [31:0] led_nxt;
	// pending summary kept in step with the flag bits
	logic pend_r;
	logic pend_nxt;
	// per-bit rising-edge hits
	logic [3:0] hit;
	logic [3:0] enable_bits;
	logic [3:0] alarm_inputs;

	input_sync input_sync_inst
	(
		.core_clk(core_clk),
		.reset(reset),
		.raw({alarm_mode_on, input_load_supply, field_in}),
		.sync(sync_all)
	);
	assign in_s = sync_all[31:0];
	assign supply_s = sync_all[32];
	assign alarm_on_s = sync_all[33];

	// pick one byte from a 32-bit word
	function automatic logic [7:0] pick_byte(input logic [31:0] w, input logic [1:0] idx);
		pick_byte = w[{idx, 3'b000} +: 8];
	endfunction

	// input gating by load supply
	always_comb
	begin
		in_eff = supply_s ? in_s : 32'h0000_0000;
		// leds follow the gated level, so they go dark with the supply
		led_nxt = in_eff;
	end

	// alarm enables live in output byte 2, inputs in input byte 2 upper nibble
	assign enable_bits = out_r[16 + `ALARM_EN_LSB +: 4];
	assign alarm_inputs = in_eff[16 + `ALARM_IN_LSB +: 4];

	// edge detection
	always_comb
	begin
		prev_nxt = alarm_inputs;
		hit = alarm_on_s ? (alarm_inputs & ~prev_r & enable_bits) : 4'h0;
	end

	// alarm byte next value: flag bits clear on read, snapshot kept, set beats clear
	always_comb
	begin
		alarm_nxt = alarm_r;
		if (bus_req.rd && bus_req.ofs == `OFS_ALARM && alarm_on_s)
			alarm_nxt[`ALARM_FLAG_LSB +: 4] = 4'h0;
		alarm_nxt[`ALARM_FLAG_LSB +: 4] = alarm_nxt[`ALARM_FLAG_LSB +: 4] | hit;
		if (hit[0])
			alarm_nxt[`ALARM_SNAP_LSB +: 4] = in_eff[3:0];
		// mode off holds nothing pending
		if (!alarm_on_s)
			alarm_nxt = `ALARM_RESET;
		// pending is taken from the value about to be stored,
		// so flag bits and the summary pin change on one edge
		pend_nxt = |alarm_nxt[`ALARM_FLAG_LSB +: 4];
	end

	// output byte writes
	always_comb
	begin
		out_nxt = out_r;
		if (bus_req.wr)
			out_nxt[{bus_req.ofs, 3'b000} +: 8] = bus_req.wdata;
	end

	// read answer
	always_comb
	begin
		rsp_nxt.rvalid = bus_req.rd;
		rsp_nxt.rdata = 8'h00;
		if (bus_req.rd)
		begin
			if (!alarm_on_s)
				rsp_nxt.rdata = pick_byte(in_eff, bus_req.ofs);
			else
			begin
				unique case (bus_req.ofs)
					`OFS_BYTE0: rsp_nxt.rdata = in_eff[7:0];
					`OFS_BYTE1: rsp_nxt.rdata = in_eff[15:8];
					`OFS_BYTE2: rsp_nxt.rdata = restart_active ? 8'h00 : in_eff[23:16];
					`OFS_ALARM: rsp_nxt.rdata = alarm_r;
				endcase
			end
		end
	end

	// output latches: only reset and byte writes change them, so plain use needs no setup write
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			// all outputs off, all alarm enables off
			out_r <= `OUT_RESET;
		end
		else
		begin
			// take the byte write, if any
			out_r <= out_nxt;
		end
	end

	// alarm byte and its pending summary move together
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			// nothing pending after reset
			alarm_r <= `ALARM_RESET;
			pend_r <= 1'b0;
		end
		else
		begin
			// set already beats read-clear inside alarm_nxt
			alarm_r <= alarm_nxt;
			pend_r <= pend_nxt;
		end
	end

	// last alarm input levels for edge detection
	// reset low matches idle inputs, so no false edge follows reset
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			prev_r <= 4'h0;
		end
		else
		begin
			prev_r <= prev_nxt;
		end
	end

	// read answer: one-cycle pulse, data stands with it
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			// no answer pending out of reset
			rsp_r <= '0;
		end
		else
		begin
			rsp_r <= rsp_nxt;
		end
	end

	// indicator levels, one cycle behind the gated inputs
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			// leds dark during reset
			led_r <= 32'h0000_0000;
		end
		else
		begin
			led_r <= led_nxt;
		end
	end

	// all data outputs straight from flip-flops
	assign field_out = out_r;
	assign bus_rsp = rsp_r;
	assign input_led = led_r;
	assign alarm_pending = pend_r;
endmodule

// file: tb/dio_alarm_chk_assertions.sv
// Purpose: port checks; Assumes: two-edge pin sync; Notes: bound below
`timescale 1ns/100ps
module dio_alarm_chk
(
	// clock, reset
	input wire logic core_clk,
	input wire logic reset,
	// watched ports
	input wire dio_alarm_pkg::bus_req_type bus_req,
	input wire dio_alarm_pkg::bus_rsp_type bus_rsp,
	input wire logic [31:0] field_in,
	input wire logic input_load_supply,
	input wire logic alarm_mode_on,
	input wire logic restart_active,
	input wire logic [31:0] field_out,
	input wire logic [31:0] input_led,
	input wire logic alarm_pending
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	property p_rv; bus_req.rd |=> bus_rsp.rvalid; endproperty
	a_rv: assert property (p_rv) else $error("rv");
	property p_wr; bus_req.wr && bus_req.ofs == 2'h0 |=> field_out[7:0] == $past(bus_req.wdata); endproperty
	a_wr: assert property (p_wr) else $error("wr");
	property p_led; !input_load_supply [*4] |-> input_led == 32'h0000_0000; endproperty
	a_led: assert property (p_led) else $error("led");
	property p_ns; !input_load_supply [*4] ##0 bus_req.rd && bus_req.ofs != 2'h3 |=> bus_rsp.rdata == 8'h00; endproperty
	a_ns: assert property (p_ns) else $error("ns");
	property p_rs; alarm_mode_on [*4] ##0 restart_active && bus_req.rd && bus_req.ofs == 2'h2 |=> bus_rsp.rdata == 8'h00; endproperty
	a_rs: assert property (p_rs) else $error("rs");
	property p_off; !alarm_mode_on [*4] |-> !alarm_pending; endproperty
	a_off: assert property (p_off) else $error("off");
	property p_b0; input_load_supply && $stable(field_in) [*4] ##0 bus_req.rd && bus_req.ofs == 2'h0 |=> bus_rsp.rdata == $past(field_in[7:0]); endproperty
	a_b0: assert property (p_b0) else $error("b0");
	property p_clr; alarm_mode_on && $stable(field_in) [*4] ##0 bus_req.rd && bus_req.ofs == 2'h3 |=> ##1 !alarm_pending; endproperty
	a_clr: assert property (p_clr) else $error("clr");
	c_ack: cover property (bus_req.rd && bus_req.ofs == 2'h3 && alarm_pending);
	c_rs: cover property (restart_active && bus_req.rd);
	c_ns: cover property (!input_load_supply && bus_req.rd);
endmodule
bind digital_io_alarm_capture dio_alarm_chk dio_alarm_chk_inst
(
	.core_clk(core_clk),
	.reset(reset),
	.bus_req(bus_req),
	.bus_rsp(bus_rsp),
	.field_in(field_in),
	.input_load_supply(input_load_supply),
	.alarm_mode_on(alarm_mode_on),
	.restart_active(restart_active),
	.field_out(field_out),
	.input_led(input_led),
	.alarm_pending(alarm_pending)
);

// file: tb/cpu_model.sv
// Purpose: controller model; Assumes: called after an edge; Notes: bus idles low
`timescale 1ns/100ps
module cpu_model
(
	// clock
	input wire logic core_clk,
	// byte bus
	output dio_alarm_pkg::bus_req_type bus_req,
	input wire dio_alarm_pkg::bus_rsp_type bus_rsp
);
	initial bus_req = '0;
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		bus_req <= '{1'b0, 1'b1, a, d};
		@(posedge core_clk);
		bus_req <= '0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		bus_req <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge core_clk);
		bus_req <= '0;
		@(posedge core_clk);
		d = bus_rsp.rdata;
	endtask
endmodule

// file: tb/digital_io_alarm_capture_tb_top.sv
// Purpose: self-checking bench; Assumes: pins seen in 2 edges; Notes: waits of 4
`timescale 1ns/100ps
module digital_io_alarm_capture_tb_top;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [31:0] field_in = 32'h0000_0000;
	logic input_load_supply = 1'b1;
	logic alarm_mode_on = 1'b0;
	logic restart_active = 1'b0;
	logic [31:0] field_out;
	logic [31:0] input_led;
	logic alarm_pending;
	logic [7:0] d;
	dio_alarm_pkg::bus_req_type bus_req;
	dio_alarm_pkg::bus_rsp_type bus_rsp;
	int num_errors = 0;
	int n_compared = 0;
	initial forever #2 core_clk = ~core_clk;
	cpu_model cpu_model_inst
	(
		.core_clk(core_clk),
		.bus_req(bus_req),
		.bus_rsp(bus_rsp)
	);
	digital_io_alarm_capture digital_io_alarm_capture_inst
	(
		.core_clk(core_clk),
		.reset(reset),
		.bus_req(bus_req),
		.bus_rsp(bus_rsp),
		.field_in(field_in),
		.input_load_supply(input_load_supply),
		.alarm_mode_on(alarm_mode_on),
		.restart_active(restart_active),
		.field_out(field_out),
		.input_led(input_led),
		.alarm_pending(alarm_pending)
	);
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			num_errors++;
			$display("BAD %s exp %h got %h", s, e, g);
		end
	endtask
	// pins settle past the sync
	task automatic setp(input logic [31:0] p);
		field_in <= p;
		repeat (4) @(posedge core_clk);
	endtask
	task automatic rchk(input string s, input logic [1:0] a, input logic [7:0] e);
		cpu_model_inst.rd(a, d);
		chk(s, e, d);
	endtask
	task automatic t_plain;
		setp(32'hc3a5_5a3c);
		for (int i = 0; i < 4; i++)
			rchk("byte", 2'(i), 8'(32'hc3a5_5a3c >> 8 * i));
		cpu_model_inst.wr(2'h3, 8'h99);
		chk("out", 8'h99, field_out[31:24]);
		$display("t_plain done");
	endtask
	task automatic t_supply;
		input_load_supply <= 1'b0;
		setp(32'hffff_ffff);
		rchk("nosup", 2'h1, 8'h00);
		chk("led", 32'h0000_0000, input_led);
		input_load_supply <= 1'b1;
		$display("t_supply done");
	endtask
	task automatic t_alarm;
		alarm_mode_on <= 1'b1;
		setp(32'h0000_0000);
		cpu_model_inst.wr(2'h2, 8'h0e);
		setp(32'h00f0_000a);
		rchk("flg", 2'h3, 8'h0e);
		cpu_model_inst.wr(2'h2, 8'h0f);
		setp(32'h0000_0005);
		rchk("fall", 2'h3, 8'h00);
		setp(32'h0010_0005);
		chk("pend", 1'b1, alarm_pending);
		rchk("snap", 2'h3, 8'h51);
		rchk("clr", 2'h3, 8'h50);
		restart_active <= 1'b1;
		rchk("rst", 2'h2, 8'h00);
		rchk("b0", 2'h0, 8'h05);
		restart_active <= 1'b0;
		$display("t_alarm done");
	endtask
	task automatic wrap_up;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		t_plain;
		t_supply;
		t_alarm;
		wrap_up;
	end
	// hang guard
	initial
	begin
		repeat (5000) @(posedge core_clk);
		num_errors++;
		wrap_up;
	end
endmodule
